/* File: common/nvcs_pkg.sv */
// Shared constants and types for the nonvolatile configuration store control.
package nvcs_pkg;

    // ========================================================================
    // Register map
    // ========================================================================
    localparam logic [7:0] CTRL_ADDR = 8'h72;
    localparam logic [7:0] SHADOW_FIRST = 8'ha0;
    localparam logic [7:0] SHADOW_LAST = 8'ha7;
    localparam int SHADOW_COUNT = 8;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // ========================================================================
    // Control register fields
    // ========================================================================
    localparam int IDLE_BIT = 7;
    localparam int ARM_BIT = 2;
    localparam int COMMIT_BIT = 1;
    localparam int RELOAD_BIT = 0;
    localparam logic [7:0] CTRL_WMASK = 8'h07;

    // ========================================================================
    // Timing
    // ========================================================================
    localparam int CLK_HZ = 40_000_000;
    localparam int NVM_OP_MS = 100;
    localparam int HOST_WAIT_MS = 200;
    localparam int NVM_OP_CYCLES = (CLK_HZ / 1000) * NVM_OP_MS;
    localparam int HOST_WAIT_CYCLES = (CLK_HZ / 1000) * HOST_WAIT_MS;

    // ========================================================================
    // Factory contents of the nonvolatile array, last byte first
    // ========================================================================
    localparam logic [63:0] NVM_FACTORY = {
        8'h2d, 8'h64, 8'hcf, 8'h28, 8'h7b, 8'hbf, 8'hf5, 8'h7f
    };

    // ========================================================================
    // Types
    // ========================================================================
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic we;
        logic re;
    } nvcs_reg_req_t;

    typedef struct packed {
        logic [SHADOW_COUNT-1:0][7:0] bytes;
    } nvcs_cfg_t;

    typedef enum logic [1:0] {
        ST_BOOT,
        ST_IDLE,
        ST_COMMIT,
        ST_RELOAD
    } nvcs_state_t;

endpackage

/* File: dv/nvcs_ctrl_sva.sv */
// Port checks for the nonvolatile configuration store control.
`timescale 1ns/1ps

module nvcs_ctrl_sva #(
    parameter int unsigned OP_CYCLES = nvcs_pkg::NVM_OP_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic fuse_rst,
    input wire nvcs_pkg::nvcs_reg_req_t reg_req,
    input wire logic [7:0] reg_rdata,
    input wire nvcs_pkg::nvcs_cfg_t cfg,
    input wire logic nvm_idle_flag
);
    // ========================================
    // Helper state
    // ========================================
    logic arm_q, arm_d, cw, sw, go;
    logic [31:0] busy_q, busy_d;
    assign cw = ce && reg_req.we && reg_req.addr == nvcs_pkg::CTRL_ADDR;
    assign sw = ce && reg_req.we && nvm_idle_flag
        && reg_req.addr[7:3] == 5'h14;
    assign go = cw && nvm_idle_flag && reg_req.wdata[1:0] != 2'h0;
    always_comb begin
        arm_d = cw ? reg_req.wdata[2] : arm_q;
        // Only enabled cycles count, since a low ce freezes the sequencer.
        busy_d = nvm_idle_flag ? 32'h0 : (ce ? busy_q + 32'h1 : busy_q);
    end
    always_ff @(posedge clk_sys) begin
        arm_q <= rst ? 1'b0 : arm_d;
        busy_q <= rst ? 32'h0 : busy_d;
    end
    // ========================================
    // Properties
    // ========================================
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    idle_readback_a: assert property (
        ce && reg_req.re && reg_req.addr == nvcs_pkg::CTRL_ADDR |=>
        reg_rdata[7] == $past(nvm_idle_flag) && reg_rdata[6:3] == 4'h0)
        else $error("ready bit readback wrong");
    unarmed_start_a: assert property (
        go && !arm_q |=> nvm_idle_flag) else $error("unarmed start ran");
    armed_start_a: assert property (
        go && arm_q |=> !nvm_idle_flag) else $error("armed start ignored");
    busy_min_a: assert property (
        $rose(nvm_idle_flag) |-> busy_q == OP_CYCLES)
        else $error("busy span wrong length");
    busy_max_a: assert property (
        busy_q <= OP_CYCLES) else $error("busy span too long");
    shadow_write_a: assert property (
        sw |=> cfg.bytes[$past(reg_req.addr[2:0])] == $past(reg_req.wdata))
        else $error("shadow write not applied");
    cfg_source_a: assert property (
        !$stable(cfg) |-> $rose(nvm_idle_flag) || $past(sw))
        else $error("shadow changed without cause");
    cover property (go && arm_q);
    cover property (go && !arm_q);
    cover property ($rose(nvm_idle_flag));
    cover property (!ce && !nvm_idle_flag);
endmodule // nvcs_ctrl_sva

bind nvcs_ctrl nvcs_ctrl_sva #(.OP_CYCLES(OP_CYCLES)) u_sva (
    .clk_sys(clk_sys), .rst(rst), .ce(ce), .fuse_rst(fuse_rst),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .cfg(cfg),
    .nvm_idle_flag(nvm_idle_flag));

/* File: dv/nvcs_ctrl_tb.sv */
// Self-checking testbench for the configuration store control.
`timescale 1ns/1ps

module nvcs_ctrl_tb;
    localparam int unsigned OPC = 8;
    localparam int unsigned WCY = 2 * OPC;
    localparam logic [7:0] CTL = nvcs_pkg::CTRL_ADDR;
    logic clk_sys, rst, ce, fuse_rst, nvm_idle_flag;
    nvcs_pkg::nvcs_reg_req_t reg_req;
    nvcs_pkg::nvcs_cfg_t cfg;
    logic [7:0] reg_rdata, seed;
    logic [7:0] exp_q[$];
    logic [63:0] img, img2;
    int n_fail = 0;
    int samples_checked = 0;

    nvcs_ctrl #(.OP_CYCLES(OPC)) dut (.clk_sys(clk_sys), .rst(rst),
        .ce(ce), .fuse_rst(fuse_rst), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .cfg(cfg), .nvm_idle_flag(nvm_idle_flag));
    nvcs_host host (.clk_sys(clk_sys), .reg_req(reg_req));

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // ========================================
    // Tasks
    // ========================================
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic check(input logic [7:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, exp);
        exp_q.push_back(exp);
        host.xfer(a, 8'h00, 1'b0);
    endtask
    task automatic rd_img(input logic [63:0] m);
        for (int i = 0; i < 8; i++) rd(8'ha0 + 8'(i), m[8*i +: 8]);
    endtask
    task automatic fill(output logic [63:0] m);
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            m[8*i +: 8] = seed;
            host.xfer(8'ha0 + 8'(i), seed, 1'b1);
        end
    endtask
    task automatic pause(input int unsigned cy);
        repeat (cy) @(posedge clk_sys);
        #2;
    endtask
    task automatic results();
        $display("Checked %0d, failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Each read answers one edge later, so the oldest note is compared then.
    always @(posedge clk_sys) begin
        if (!rst && reg_req.re) begin
            #1;
            check(reg_rdata, exp_q.pop_front());
        end
    end
    initial begin
        pause(3000);
        n_fail++;
        $display("Error at %0t: watchdog expired", $time);
        results();
    end
    // ========================================
    // Main sequence
    // ========================================
    initial begin
        seed = 8'h09;
        ce = 1'b1;
        fuse_rst = 1'b1;
        rst = 1'b1;
        pause(12);
        rst = 1'b0;
        fuse_rst = 1'b0;
        rd(CTL, 8'h00);
        pause(WCY);
        rd(CTL, 8'h80);
        rd_img(nvcs_pkg::NVM_FACTORY);
        $display("Test boot done");
        host.xfer(8'h01, 8'h05, 1'b1);
        fill(img);
        rd_img(img);
        host.xfer(CTL, 8'h02, 1'b1);
        rd(CTL, 8'h82);
        host.xfer(CTL, 8'h01, 1'b1);
        rd(CTL, 8'h81);
        $display("Test unarmed done");
        host.start_op(8'h02);
        rd(CTL, 8'h02);
        host.xfer(8'ha0, ~img[7:0], 1'b1);
        host.finish_op(WCY);
        rd(CTL, 8'h80);
        rd(8'ha0, img[7:0]);
        ce = 1'b0;
        host.xfer(8'ha1, ~img[15:8], 1'b1);
        ce = 1'b1;
        rd(8'ha1, img[15:8]);
        $display("Test commit done");
        fill(img2);
        host.start_op(8'h01);
        rd(CTL, 8'h01);
        ce = 1'b0;
        pause(4);
        ce = 1'b1;
        rd(CTL, 8'h01);
        host.finish_op(WCY);
        rd_img(img);
        $display("Test reload done");
        fill(img2);
        rst = 1'b1;
        pause(12);
        rst = 1'b0;
        pause(WCY);
        rd_img(img);
        rd(8'h01, nvcs_pkg::UNMAPPED_READ);
        $display("Test power cycle done");
        pause(4);
        results();
    end
endmodule // nvcs_ctrl_tb

/* File: dv/nvcs_host.sv */
// Host model issuing requests on the store's register port.
`timescale 1ns/1ps

module nvcs_host (
    input wire logic clk_sys,
    output nvcs_pkg::nvcs_reg_req_t reg_req
);
    // ========================================
    // Register port cycles
    // ========================================
    initial reg_req = '0;
    // Idle fields carry inverted values so stale data is never trusted.
    task automatic xfer(input logic [7:0] a, d, input logic w);
        reg_req = '{a, d, w, !w};
        @(posedge clk_sys);
        #2;
        reg_req = '{~a, ~d, 1'b0, 1'b0};
        @(posedge clk_sys);
        #2;
    endtask
    task automatic start_op(input logic [7:0] code);
        xfer(nvcs_pkg::CTRL_ADDR, 8'h04, 1'b1);
        xfer(nvcs_pkg::CTRL_ADDR, code, 1'b1);
    endtask
    // Busy time is unknown to a host, so it always waits the full span.
    task automatic finish_op(input int unsigned cy);
        repeat (cy) @(posedge clk_sys);
        #2;
        xfer(nvcs_pkg::CTRL_ADDR, 8'h00, 1'b1);
    endtask
endmodule // nvcs_host

/* File: hw/nvcs_ctrl.sv */
// Control and status logic of the nonvolatile configuration store.
`timescale 1ns/1ps

// Overview of operation
// R1 - Bit 7 reads 1 only when idle.
// R2 - Host sets arm bit before any operation.
// R3 - Host enables device with 05h at 01h; the control does not decode 01h and ignores the write.
// R4 - Host fills shadow bytes A0h-A7h first.
// R5 - Host writes 04h then 02h to 72h.
// R6 - Commit copies shadow to memory; host waits.
// R7 - Reload copies memory to shadow after 04h,01h.
// R8 - Shadow writes take effect immediately; the control drops shadow writes while an operation runs.
// R9 - Uncommitted shadow values lost on power cycle.
// R10 - Startup loads memory into shadow automatically.
// R11 - Start without arm does nothing, stays idle.

module nvcs_ctrl #(
    parameter int unsigned OP_CYCLES = nvcs_pkg::NVM_OP_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic fuse_rst,
    input wire nvcs_pkg::nvcs_reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    output nvcs_pkg::nvcs_cfg_t cfg,
    output logic nvm_idle_flag
);

    // ========================================================================
    // Decode helpers
    // ========================================================================
    function automatic logic is_shadow(input logic [7:0] addr);
        is_shadow = (addr >= nvcs_pkg::SHADOW_FIRST) &&
                    (addr <= nvcs_pkg::SHADOW_LAST);
    endfunction

    function automatic logic [2:0] shadow_idx(input logic [7:0] addr);
        logic [7:0] off;
        off = addr - nvcs_pkg::SHADOW_FIRST;
        shadow_idx = off[2:0];
    endfunction

    // ========================================================================
    // State
    // ========================================================================
    nvcs_pkg::nvcs_state_t st_q;
    nvcs_pkg::nvcs_state_t st_d;
    logic [31:0] cnt_q;
    logic [31:0] cnt_d;
    logic [7:0] ctrl_q;
    logic [7:0] ctrl_d;
    logic [7:0][7:0] shadow_q;
    logic [7:0][7:0] shadow_d;
    logic [7:0][7:0] snap_q;
    logic [7:0][7:0] snap_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic commit_we_q;
    logic commit_we_d;
    logic idle_q;
    logic idle_d;
    logic [63:0] nvm_data;
    logic [31:0] last_cnt;
    logic op_done;
    logic start_ok;
    logic start_commit;
    logic start_reload;
    logic load_shadow;

    assign last_cnt = 32'(OP_CYCLES - 1);
    assign op_done = (cnt_q >= last_cnt);

    // A start needs the arm bit stored by an earlier write; a start write
    // without it is stored and readable but runs nothing.
    assign start_ok = reg_req.we && (reg_req.addr == nvcs_pkg::CTRL_ADDR) &&
                      (st_q == nvcs_pkg::ST_IDLE) &&
                      ctrl_q[nvcs_pkg::ARM_BIT]; // [R2] [R11]
    assign start_commit = start_ok && reg_req.wdata[nvcs_pkg::COMMIT_BIT];
    assign start_reload = start_ok && !reg_req.wdata[nvcs_pkg::COMMIT_BIT] &&
                          reg_req.wdata[nvcs_pkg::RELOAD_BIT];
    assign load_shadow = op_done && ((st_q == nvcs_pkg::ST_BOOT) ||
                                     (st_q == nvcs_pkg::ST_RELOAD));

    // ========================================================================
    // Nonvolatile array
    // ========================================================================
    // The written image is the snapshot taken at start, so shadow writes
    // arriving during a commit cannot tear the stored image.
    nvcs_nvm_cell u_cell (
        .clk_sys(clk_sys),
        .fuse_rst(fuse_rst),
        .ce(ce),
        .wr_en(commit_we_q),
        .wr_data(snap_q),
        .rd_data(nvm_data)
    );

    // ========================================================================
    // Sequencer: boot load, commit and reload
    // ========================================================================
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        snap_d = snap_q;
        commit_we_d = 1'b0;

        case (st_q)
            nvcs_pkg::ST_IDLE: begin
                if (start_commit) begin // [R5]
                    st_d = nvcs_pkg::ST_COMMIT;
                    snap_d = shadow_q; // [R6]
                    cnt_d = 32'h0000_0000;
                end else if (start_reload) begin
                    st_d = nvcs_pkg::ST_RELOAD; // [R7]
                    cnt_d = 32'h0000_0000;
                end
            end
            nvcs_pkg::ST_BOOT: begin
                if (op_done) begin
                    st_d = nvcs_pkg::ST_IDLE; // [R10]
                    cnt_d = 32'h0000_0000;
                end else begin
                    cnt_d = cnt_q + 32'h0000_0001;
                end
            end
            nvcs_pkg::ST_COMMIT: begin
                if (op_done) begin
                    commit_we_d = 1'b1; // [R6]
                    st_d = nvcs_pkg::ST_IDLE;
                    cnt_d = 32'h0000_0000;
                end else begin
                    cnt_d = cnt_q + 32'h0000_0001;
                end
            end
            nvcs_pkg::ST_RELOAD: begin
                if (op_done) begin
                    st_d = nvcs_pkg::ST_IDLE; // [R7]
                    cnt_d = 32'h0000_0000;
                end else begin
                    cnt_d = cnt_q + 32'h0000_0001;
                end
            end
            default: begin
            end
        endcase

        idle_d = (st_d == nvcs_pkg::ST_IDLE); // [R1]
    end

    // ========================================================================
    // Register file: control byte, shadow bytes and read data
    // ========================================================================
    always_comb begin
        ctrl_d = ctrl_q;
        shadow_d = shadow_q;
        rdata_d = rdata_q;

        if (load_shadow) begin
            shadow_d = nvm_data; // [R7] [R10]
        end

        // Shadow writes are dropped while an operation runs so that a
        // reload or boot image is not overwritten halfway.
        if (reg_req.we) begin
            if (is_shadow(reg_req.addr)) begin
                if (st_q == nvcs_pkg::ST_IDLE) begin
                    shadow_d[shadow_idx(reg_req.addr)] = reg_req.wdata; // [R8]
                end
            end else if (reg_req.addr == nvcs_pkg::CTRL_ADDR) begin
                ctrl_d = reg_req.wdata & nvcs_pkg::CTRL_WMASK;
            end
        end

        // Register reads.
        if (reg_req.re) begin
            if (is_shadow(reg_req.addr)) begin
                rdata_d = shadow_q[shadow_idx(reg_req.addr)];
            end else if (reg_req.addr == nvcs_pkg::CTRL_ADDR) begin
                rdata_d = ctrl_q;
                rdata_d[nvcs_pkg::IDLE_BIT] = idle_q; // [R1]
            end else begin
                rdata_d = nvcs_pkg::UNMAPPED_READ;
            end
        end

    end

    // ========================================================================
    // Registers
    // ========================================================================
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_q <= nvcs_pkg::ST_BOOT; // [R10]
            cnt_q <= 32'h0000_0000;
            snap_q <= '0;
            commit_we_q <= 1'b0;
            idle_q <= 1'b0;
        end else if (ce) begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            snap_q <= snap_d;
            commit_we_q <= commit_we_d;
            idle_q <= idle_d;
        end
    end

    // The shadow bytes clear on rst, which models losing them at power
    // off; the boot load and each reload refill them from the array.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl_q <= nvcs_pkg::CTRL_RESET;
            shadow_q <= '0; // [R9]
            rdata_q <= 8'h00;
        end else if (ce) begin
            ctrl_q <= ctrl_d;
            shadow_q <= shadow_d;
            rdata_q <= rdata_d;
        end
    end

    // ========================================================================
    // Outputs
    // ========================================================================
    assign reg_rdata = rdata_q;
    assign cfg.bytes = shadow_q; // [R8]
    assign nvm_idle_flag = idle_q;

endmodule // nvcs_ctrl

/* File: hw/nvcs_nvm_cell.sv */
// Nonvolatile storage array that keeps its contents across the logic reset.
`timescale 1ns/1ps

module nvcs_nvm_cell (
    input wire logic clk_sys,
    input wire logic fuse_rst,
    input wire logic ce,
    input wire logic wr_en,
    input wire logic [63:0] wr_data,
    output logic [63:0] rd_data
);

    // ========================================================================
    // Storage
    // ========================================================================
    // The array ignores rst on purpose: rst stands for a power cycle, and
    // only a commit or fuse_rst may change what is stored.
    logic [7:0][7:0] mem_q;
    logic [7:0][7:0] mem_d;

    always_comb begin
        mem_d = mem_q;
        if (wr_en) begin
            mem_d = wr_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (fuse_rst) begin
            mem_q <= nvcs_pkg::NVM_FACTORY;
        end else if (ce) begin
            mem_q <= mem_d;
        end
    end

    assign rd_data = mem_q;

endmodule // nvcs_nvm_cell
